// file: hdl/bbct_pkg.sv
// constants and types of the buffered byte count tracker
// assumes one 100 MHz clock domain shared by host port and bus engine
package bbct_pkg;
  localparam int BUF_DEPTH = 68;
  localparam int PTR_W = 7;
  localparam logic [6:0] PTR_LAST = 7'h43; // last buffer location
  localparam logic [6:0] PTR_FIRST = 7'h00;
  localparam logic [6:0] BC_MAX = 7'h44; // largest legal byte count
  localparam logic [6:0] BC_ZERO = 7'h00;
  localparam int LB_POS = 7; // last-byte flag position in count register
  localparam int BC_MSB = 6; // top bit of byte count field
  localparam logic [7:0] COUNT_RST = 8'h00;
  localparam logic [7:0] STA_IDLE = 8'hF8; // status after reset
  localparam logic [7:0] STA_BAD_COUNT = 8'hFC; // invalid count requested

  typedef enum logic [1:0] {
    ROLE_MT,
    ROLE_MR,
    ROLE_ST,
    ROLE_SR
  } bbct_role_t;

  // host strobes, each one cycle wide
  typedef struct packed {
    logic wr_count;
    logic wr_data;
    logic rd_data;
    logic wr_ctrl;
    logic [7:0] wdata;
  } bbct_host_t;

  // bus engine events, each one cycle wide except role and data
  typedef struct packed {
    bbct_role_t role;
    logic addr_done;
    logic addr_ack;
    logic slv_addr;
    logic byte_done;
    logic [7:0] rx_byte;
    logic seq_end;
  } bbct_eng_t;
endpackage

// file: hdl/bbct_buf.sv
// 68-byte data buffer with one write and one registered read port
// assumes write and read addresses stay inside the buffer
`timescale 1ns/100ps
module bbct_buf (
  input wire logic clk_sys,
  input wire logic wr_en,
  input wire logic [6:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic [6:0] rd_addr,
  output logic [7:0] rd_data_q
);
  logic [7:0] mem_q [0:bbct_pkg::BUF_DEPTH-1];

  // storage write
  always_ff @(posedge clk_sys) begin
    if (wr_en) begin
      mem_q[wr_addr] <= wr_data;
    end
  end

  // read with write-through so the output never shows a stale byte
  always_ff @(posedge clk_sys) begin
    if (wr_en && (wr_addr == rd_addr)) begin
      rd_data_q <= wr_data;
    end else begin
      rd_data_q <= mem_q[rd_addr];
    end
  end
endmodule

// file: hdl/bbct_top.sv
// byte count and buffer pointer tracking for buffered transfers
// assumes host strobes and engine events come from logic on clk_sys
// How it works
// [RULE1] count register write rewinds buffer pointer
// [RULE2] sequence end loads bytes moved into count
// [RULE3] transmission starts from first buffer location
// [RULE4] receive sequence end rewinds pointer to start
// [RULE5] master transmit address alone counts one
// [RULE6] master transmit address plus n gives n+1
// [RULE7] arbitration lost in address gives zero
// [RULE8] arbitration lost mid data counts completed bytes
// [RULE9] master receive: address nack one, data n
// [RULE10] arbitration lost in ack keeps n
// [RULE11] slave receive address gives zero, then n
// [RULE12] slave transmit address gives zero, then n
// [RULE13] count undefined after start, stop, acked read
// [RULE14] zero or above 68 rejects with FCh
// [RULE15] host programs count between 01h and 44h
// [RULE16] last byte flag makes final byte nacked
// [RULE17] data port writes past 68 wrap to 00h
// [RULE18] pointer steps on each access and byte; a host access and a byte in the same cycle step it only once
`timescale 1ns/100ps
module bbct_top (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire bbct_pkg::bbct_host_t host,
  input wire bbct_pkg::bbct_eng_t eng,
  output logic [7:0] count_rdata,
  output logic [7:0] data_rdata,
  output logic [7:0] tx_byte,
  output logic [7:0] status_q,
  output logic [6:0] ptr_q,
  output logic start_seq_q,
  output logic reject_irq_q,
  output logic ack_out
);
  logic [6:0] bc_q;
  logic [6:0] bc_d;
  logic lb_q;
  logic lb_d;
  logic [6:0] cnt_q;
  logic [6:0] cnt_d;
  logic [6:0] ptr_d;
  logic [7:0] status_d;
  logic start_seq_d;
  logic reject_irq_d;
  logic rx_role;
  logic bc_bad;
  logic host_data_acc;
  logic eng_move;
  logic buf_wr_en;
  logic [7:0] buf_wr_data;
  logic [7:0] buf_q;
  logic [7:0] first_byte_q;
  logic [7:0] first_byte_d;
  logic moved_q;
  logic moved_d;

  // pointer step with wrap at the end of the buffer
  function automatic logic [6:0] ptr_next(input logic [6:0] p);
    if (p == bbct_pkg::PTR_LAST) begin
      ptr_next = bbct_pkg::PTR_FIRST;
    end else begin
      ptr_next = p + 7'h01;
    end
  endfunction

  // decode of roles and events
  assign rx_role = (eng.role == bbct_pkg::ROLE_MR) || (eng.role == bbct_pkg::ROLE_SR);
  assign bc_bad = (bc_q == bbct_pkg::BC_ZERO) || (bc_q > bbct_pkg::BC_MAX); // RULE14 RULE15
  assign host_data_acc = host.wr_data || host.rd_data;
  assign eng_move = eng.byte_done;

  // buffer write from host or from received bytes
  always_comb begin
    buf_wr_en = 1'b0;
    buf_wr_data = host.wdata;
    if (host.wr_data) begin
      buf_wr_en = 1'b1;
    end else if (eng.byte_done && rx_role) begin
      buf_wr_en = 1'b1;
      buf_wr_data = eng.rx_byte;
    end
  end

  bbct_buf u_buf (
    .clk_sys(clk_sys),
    .wr_en(buf_wr_en),
    .wr_addr(ptr_q),
    .wr_data(buf_wr_data),
    .rd_addr(ptr_d),
    .rd_data_q(buf_q)
  );

  // next values of pointer, counts, status and strobes
  always_comb begin
    ptr_d = ptr_q;
    cnt_d = cnt_q;
    bc_d = bc_q;
    lb_d = lb_q;
    status_d = status_q;
    start_seq_d = 1'b0;
    reject_irq_d = 1'b0;
    // pointer
    if (host.wr_count) begin
      ptr_d = bbct_pkg::PTR_FIRST; // RULE1
    end else if (host.wr_ctrl && !bc_bad) begin
      ptr_d = bbct_pkg::PTR_FIRST; // RULE3
    end else if (eng.seq_end && rx_role) begin
      ptr_d = bbct_pkg::PTR_FIRST; // RULE4
    end else if (eng.slv_addr) begin
      ptr_d = bbct_pkg::PTR_FIRST;
    end else if (host_data_acc || eng_move) begin
      ptr_d = ptr_next(ptr_q); // RULE17 RULE18
    end
    // bytes moved in the running sequence; value between start and end is unspecified
    if (host.wr_ctrl || eng.slv_addr) begin
      cnt_d = 7'h00; // RULE11 RULE12 RULE13
    end else if (eng.addr_done) begin
      // master transmit counts its address; master receive only when nacked
      if (eng.role == bbct_pkg::ROLE_MT) begin
        cnt_d = cnt_q + 7'h01; // RULE5
      end else if ((eng.role == bbct_pkg::ROLE_MR) && !eng.addr_ack) begin
        cnt_d = cnt_q + 7'h01; // RULE9
      end
    end else if (eng.byte_done) begin
      // only finished bytes count, so a lost byte is never included
      cnt_d = cnt_q + 7'h01; // RULE6 RULE7 RULE8 RULE10
    end
    // count register: host write or report at sequence end
    if (host.wr_count) begin
      bc_d = host.wdata[bbct_pkg::BC_MSB:0];
      lb_d = host.wdata[bbct_pkg::LB_POS];
    end else if (eng.seq_end) begin
      bc_d = cnt_q; // RULE2
    end
    // sequence start or rejection on control write
    if (host.wr_ctrl) begin
      if (bc_bad) begin
        status_d = bbct_pkg::STA_BAD_COUNT; // RULE14
        reject_irq_d = 1'b1;
      end else begin
        start_seq_d = 1'b1;
      end
    end
  end

  // state registers
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ptr_q <= bbct_pkg::PTR_FIRST;
      cnt_q <= 7'h00;
      bc_q <= bbct_pkg::COUNT_RST[bbct_pkg::BC_MSB:0];
      lb_q <= bbct_pkg::COUNT_RST[bbct_pkg::LB_POS];
      status_q <= bbct_pkg::STA_IDLE;
      start_seq_q <= 1'b0;
      reject_irq_q <= 1'b0;
    end else begin
      ptr_q <= ptr_d;
      cnt_q <= cnt_d;
      bc_q <= bc_d;
      lb_q <= lb_d;
      status_q <= status_d;
      start_seq_q <= start_seq_d;
      reject_irq_q <= reject_irq_d;
    end
  end

  // checking aids: byte held at the first location, and any move since start
  always_comb begin
    first_byte_d = first_byte_q;
    moved_d = moved_q;
    if (buf_wr_en && (ptr_q == bbct_pkg::PTR_FIRST)) begin
      first_byte_d = buf_wr_data;
    end
    if (host.wr_ctrl || eng.slv_addr) begin
      moved_d = 1'b0;
    end else if (eng.addr_done || eng.byte_done) begin
      moved_d = 1'b1;
    end
  end

  // checking aid registers; the byte copy has no reset, like the buffer
  always_ff @(posedge clk_sys) begin
    first_byte_q <= first_byte_d;
    if (sys_rst) begin
      moved_q <= 1'b0;
    end else begin
      moved_q <= moved_d;
    end
  end

  // read data and acknowledge decision
  assign count_rdata = {lb_q, bc_q};
  assign data_rdata = buf_q;
  assign tx_byte = buf_q; // RULE3
  assign ack_out = !(rx_role && lb_q && ((cnt_q + 7'h01) == bc_q)); // RULE16

  a_count_wr_rewind: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE1
    host.wr_count |=> (ptr_q == 7'h00))
    else $error("pointer not rewound by count write");

  a_ptr_wrap: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE17
    (host.wr_data && !host.wr_count && !host.wr_ctrl && !eng.seq_end && !eng.slv_addr
      && ptr_q == 7'h43) |=> (ptr_q == 7'h00))
    else $error("pointer did not wrap to location zero");

  a_ptr_step: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE18
    (host.rd_data && !host.wr_count && !host.wr_ctrl && !eng.seq_end && !eng.slv_addr
      && ptr_q < 7'h43) |=> (ptr_q == $past(ptr_q) + 7'h01))
    else $error("pointer did not step on data access");

  a_seq_report: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE2
    (eng.seq_end && !host.wr_count) |=> (bc_q == $past(cnt_q)))
    else $error("count not reported at sequence end");

  a_start_first: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE3
    (host.wr_ctrl && !bc_bad && !host.wr_count) |=> (start_seq_q && ptr_q == 7'h00))
    else $error("sequence did not start at first location");

  a_rx_rewind: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE4
    (eng.seq_end && rx_role) |=> (ptr_q == 7'h00))
    else $error("receive pointer not rewound");

  a_mt_addr_one: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE5
    (eng.addr_done && eng.role == bbct_pkg::ROLE_MT && cnt_q == 7'h00
      && !host.wr_ctrl && !eng.slv_addr) |=> (cnt_q == 7'h01))
    else $error("master transmit address did not count one");

  a_mr_addr_ack: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE9
    (eng.addr_done && eng.addr_ack && eng.role == bbct_pkg::ROLE_MR
      && !host.wr_ctrl && !eng.slv_addr) |=> $stable(cnt_q))
    else $error("acked read address was counted");

  a_slave_zero: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE11 RULE12
    eng.slv_addr |=> (cnt_q == 7'h00))
    else $error("slave address did not clear count");

  a_bad_count: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE14
    (host.wr_ctrl && bc_bad) |=> (reject_irq_q && !start_seq_q
      && status_q == bbct_pkg::STA_BAD_COUNT))
    else $error("invalid count not rejected");

  a_last_nack: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE16
    (rx_role && lb_q && (cnt_q == bc_q - 7'h01)) |-> !ack_out)
    else $error("final byte acknowledged with last byte flag");

  a_byte_count: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE6
    (eng.byte_done && !eng.addr_done && !host.wr_ctrl && !eng.slv_addr)
      |=> (cnt_q == $past(cnt_q) + 7'h01))
    else $error("moved byte not counted");

  a_tx_first: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE3
    start_seq_q |-> (tx_byte == first_byte_q))
    else $error("first byte sent is not the first stored byte");

  a_lost_addr_zero: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE7
    (eng.seq_end && !moved_q && !eng.addr_done && !eng.byte_done && !host.wr_count
      && !host.wr_ctrl && !eng.slv_addr) |=> (bc_q == bbct_pkg::BC_ZERO))
    else $error("sequence without moves did not report zero");

  a_mr_addr_nack: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE9
    (eng.addr_done && !eng.addr_ack && eng.role == bbct_pkg::ROLE_MR
      && !host.wr_ctrl && !eng.slv_addr) |=> (cnt_q == $past(cnt_q) + 7'h01))
    else $error("refused read address was not counted");

  a_ack_default: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE16
    (!rx_role || !lb_q) |-> ack_out)
    else $error("byte refused although last byte flag is clear");

  a_eng_step: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE18
    (eng.byte_done && !host.rd_data && !host.wr_data && !host.wr_count && !host.wr_ctrl
      && !eng.seq_end && !eng.slv_addr && ptr_q < bbct_pkg::PTR_LAST)
      |=> (ptr_q == $past(ptr_q) + 7'h01))
    else $error("pointer did not step on moved byte");

  a_reject_idle: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE14
    (host.wr_ctrl && bc_bad && !host.wr_count && !host_data_acc && !eng.seq_end
      && !eng.slv_addr && !eng.byte_done) |=> ($stable(ptr_q) && !start_seq_q))
    else $error("rejected control write moved data");

  a_count_load: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE1
    host.wr_count |=> (count_rdata == $past(host.wdata)))
    else $error("count register write did not land");

  a_ctrl_restart: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE8
    host.wr_ctrl |=> (cnt_q == 7'h00))
    else $error("control write did not restart counting");

  a_status_hold: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE14
    !(host.wr_ctrl && bc_bad) |=> $stable(status_q))
    else $error("status changed without rejected control write");

  a_lb_hold: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE16
    !host.wr_count |=> $stable(lb_q))
    else $error("last byte flag changed without count write");

  a_bc_hold: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE2
    (!host.wr_count && !eng.seq_end) |=> $stable(bc_q))
    else $error("byte count field changed without cause");

  a_slave_rewind: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE12
    eng.slv_addr |=> (ptr_q == bbct_pkg::PTR_FIRST))
    else $error("slave address did not rewind pointer");
endmodule

// file: verif/bbct_eng_model.sv
// bus engine model: event pulses from the serial side of the tracker
// assumes the bench calls ev from one process on clk_sys
`timescale 1ns/100ps
module bbct_eng_model (
  input wire logic clk_sys,
  output bbct_pkg::bbct_eng_t eng
);
  initial eng = '0;
  // one event; a lost byte is no byte pulse before the end
  task ev(input bbct_pkg::bbct_role_t r, input logic [3:0] k, input logic a,
    input logic [7:0] d);
    @(posedge clk_sys);
    eng <= {r, k[3], a, k[2], k[1], d, k[0]};
    @(posedge clk_sys);
    eng <= {r, 4'h0, ~d, 1'b0}; // stale byte shows inverse
  endtask
endmodule

// file: verif/buffered_byte_count_tracker_tb.sv
// bench for the byte count tracker: host strobes and engine events
// assumes the engine model answers each event in two clk_sys edges
`timescale 1ns/100ps
module buffered_byte_count_tracker_tb;
  localparam logic [3:0] WC = 4'h8, WD = 4'h4, RD = 4'h2, CT = 4'h1;
  localparam logic [3:0] AD = 4'h8, SA = 4'h4, BD = 4'h2, SE = 4'h1;
  localparam bbct_pkg::bbct_role_t MT = bbct_pkg::ROLE_MT, MR = bbct_pkg::ROLE_MR;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  bbct_pkg::bbct_host_t host = '0;
  bbct_pkg::bbct_eng_t eng;
  logic [7:0] count_rdata, data_rdata, tx_byte, status_q;
  logic [6:0] ptr_q;
  logic start_seq_q, reject_irq_q, ack_out;
  int n_fail = 0;
  int compares = 0;
  bbct_top u_bbct_top (.clk_sys(clk_sys), .sys_rst(sys_rst), .host(host), .eng(eng),
    .count_rdata(count_rdata), .data_rdata(data_rdata), .tx_byte(tx_byte),
    .status_q(status_q), .ptr_q(ptr_q), .start_seq_q(start_seq_q),
    .reject_irq_q(reject_irq_q), .ack_out(ack_out));
  bbct_eng_model u_bbct_eng_model (.clk_sys(clk_sys), .eng(eng));
  // 100 MHz clock
  initial begin
    forever #5 clk_sys = ~clk_sys;
  end
  // helpers: host strobe, engine event, settle, compare
  task h(input logic [3:0] k, input logic [7:0] d);
    @(posedge clk_sys);
    host <= {k, d};
    @(posedge clk_sys);
    host <= '0;
  endtask
  task e(input bbct_pkg::bbct_role_t r, input logic [3:0] k, input logic a,
    input logic [7:0] d);
    u_bbct_eng_model.ev(r, k, a, d);
  endtask
  task w(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task fin(input bbct_pkg::bbct_role_t r);
    e(r, SE, 1'b0, 8'h00);
    w(2);
  endtask
  task st(input logic [7:0] c);
    h(WC, c);
    h(CT, 8'h00);
  endtask
  task chk(input logic [7:0] g, input logic [7:0] x);
    compares++;
    if (g !== x) begin
      n_fail++;
      $display("ERROR %0t: got %h want %h", $time, g, x);
    end
  endtask
  task end_sim;
    $display("fails %0d compares %0d", n_fail, compares);
    if (n_fail == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // master transmit: pointer, first byte, counts
  task t_mt;
    h(WC, 8'h02);
    h(WD, 8'hA0);
    h(WD, 8'h08);
    w(0);
    chk(8'(ptr_q), 8'h02);
    h(WC, 8'h02);
    w(0);
    chk(8'(ptr_q), 8'h00);
    h(CT, 8'h00);
    w(0);
    chk(8'(start_seq_q), 8'h01);
    w(1);
    chk(tx_byte, 8'hA0);
    e(MT, AD, 1'b1, 8'h00);
    e(MT, BD, 1'b0, 8'h00);
    fin(MT);
    chk(8'(count_rdata[6:0]), 8'h02);
    st(8'h02);
    e(MT, AD, 1'b0, 8'h00);
    fin(MT);
    chk(8'(count_rdata[6:0]), 8'h01);
    st(8'h02);
    fin(MR);
    chk(8'(count_rdata[6:0]), 8'h00);
    st(8'h03);
    e(MT, AD, 1'b1, 8'h00);
    e(MT, BD, 1'b0, 8'h00);
    fin(MT);
    chk(8'(count_rdata[6:0]), 8'h02);
    st(8'h03);
    e(MT, AD, 1'b1, 8'h00);
    fin(MT);
    chk(8'(count_rdata[6:0]), 8'h01);
    h(CT, 8'h00);
    e(MT, BD, 1'b0, 8'h00);
    fin(MT);
    chk(8'(count_rdata[6:0]), 8'h01);
    $display("master transmit done");
  endtask
  // master receive with last byte refused, rewind, read back
  task t_mr;
    st(8'h82);
    e(MR, AD, 1'b1, 8'h00);
    w(0);
    chk(8'(ack_out), 8'h01);
    e(MR, BD, 1'b0, 8'h5A);
    w(0);
    chk(8'(ack_out), 8'h00);
    e(MR, BD, 1'b0, 8'hC3);
    fin(MR);
    chk(count_rdata, 8'h82);
    chk(8'(ptr_q), 8'h00);
    chk(data_rdata, 8'h5A);
    h(RD, 8'h00);
    w(1);
    chk(data_rdata, 8'hC3);
    st(8'h02);
    e(MR, AD, 1'b0, 8'h00);
    fin(MR);
    chk(8'(count_rdata[6:0]), 8'h01);
    $display("master receive done");
  endtask
  // slave roles: address alone, then three bytes
  task t_slv(input bbct_pkg::bbct_role_t r);
    e(r, SA, 1'b0, 8'h00);
    fin(r);
    chk(8'(count_rdata[6:0]), 8'h00);
    st(8'h03);
    repeat (3) e(r, BD, 1'b0, 8'h11);
    fin(r);
    chk(8'(count_rdata[6:0]), 8'h03);
    $display("slave role done");
  endtask
  // invalid counts 00h and 45h are refused
  task t_bad;
    for (int i = 0; i < 2; i++) begin
      st(i == 0 ? 8'h00 : 8'h45);
      w(0);
      chk(8'(reject_irq_q), 8'h01);
      chk(8'(start_seq_q), 8'h00);
      chk(status_q, bbct_pkg::STA_BAD_COUNT);
    end
    $display("invalid count done");
  endtask
  // reset in mid-run restores idle values
  task t_rst;
    @(posedge clk_sys);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    w(0);
    chk(count_rdata, bbct_pkg::COUNT_RST);
    chk(status_q, bbct_pkg::STA_IDLE);
    chk(8'(ptr_q), 8'h00);
    chk(8'(reject_irq_q), 8'h00);
    $display("reset done");
  endtask
  // 69 writes wrap onto location 00h
  task t_wrap;
    h(WC, 8'h01);
    for (int i = 0; i < 69; i++) h(WD, i == 68 ? 8'hE5 : 8'(i));
    w(0);
    chk(8'(ptr_q), 8'h01);
    h(WC, 8'h01);
    w(1);
    chk(data_rdata, 8'hE5);
    $display("wrap done");
  endtask
  // main sequence
  initial begin
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    w(0);
    chk(count_rdata, bbct_pkg::COUNT_RST);
    chk(status_q, bbct_pkg::STA_IDLE);
    chk(8'(ptr_q), 8'h00);
    t_mt();
    t_mr();
    t_slv(bbct_pkg::ROLE_SR);
    t_slv(bbct_pkg::ROLE_ST);
    t_bad();
    t_rst();
    t_wrap();
    end_sim();
  end
  // hang guard
  initial begin
    #100000;
    n_fail++;
    end_sim();
  end
endmodule
